// ===== logic/cflu_pkg.sv
// constants and types of the condition-field logic unit
package cflu_pkg;
    // primary and extended opcodes
    localparam logic [5:0] OPC_X_FORM   = 6'h1f;   // 31
    localparam logic [5:0] OPC_CMPLI    = 6'h0a;   // 10
    localparam logic [5:0] OPC_XL_FORM  = 6'h13;   // 19
    localparam logic [9:0] XO_CMPL      = 10'h020; // 32
    localparam logic [9:0] XO_CLZ       = 10'h01a; // 26
    localparam logic [9:0] XO_CR_AND    = 10'h101; // 257
    localparam logic [9:0] XO_CR_ANDC   = 10'h081; // 129
    localparam logic [9:0] XO_CR_EQV    = 10'h121; // 289
    localparam logic [9:0] XO_CR_NAND   = 10'h0e1; // 225
    localparam logic [9:0] XO_CR_NOR    = 10'h021; // 33
    localparam logic [9:0] XO_CR_OR     = 10'h1c1; // 449
    localparam logic [9:0] XO_CR_ORC    = 10'h1a1; // 417

    // instruction field positions (bit 31 of the word is its msb)
    localparam int OPC_HI   = 31;
    localparam int FLD_HI   = 25;  // dest_field_selector, 3 bits
    localparam int DSTB_HI  = 25;  // dest_bit_selector / count_source_reg
    localparam int SRCA_HI  = 20;  // first_bit_selector / first_source_reg
    localparam int SRCB_HI  = 15;  // second_bit_selector / second_source_reg
    localparam int XO_HI    = 10;
    localparam int REC_POS  = 0;   // record_bit
    localparam int IMM_W    = 16;

    // wishbone register offsets (byte addresses)
    localparam logic [3:0] OFS_COND   = 4'h0;
    localparam logic [3:0] OFS_FXEXC  = 4'h4;
    localparam logic [3:0] OFS_COUNT  = 4'h8;
    localparam int         SO_POS     = 31;  // summary overflow, msb of fixed_point_exception_reg

    localparam logic [31:0] COND_RST  = 32'h0000_0000;
    localparam logic        SO_RST    = 1'b0;

    typedef enum {
        CFLU_OP_NONE,
        CFLU_OP_CMPL,
        CFLU_OP_CMPLI,
        CFLU_OP_CLZ,
        CFLU_OP_CRLOG
    } cflu_op_t;
endpackage

// ===== logic/cflu_unit.sv
// condition-field logic unit: logical compares, leading-zero count, condition-bit logic
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
module cflu_unit #(
    parameter int DATA_W = 32,
    parameter int ADR_W  = 4
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // instruction issue from decode
    input  wire logic              issue_valid_i,
    input  wire logic [31:0]       issue_instr_i,
    input  wire logic [DATA_W-1:0] first_source_reg_i,
    input  wire logic [DATA_W-1:0] second_source_reg_i,
    input  wire logic [DATA_W-1:0] count_source_reg_i,
    // general register write-back
    output logic                   gpr_wr_en_o,
    output logic [4:0]             gpr_wr_idx_o,
    output logic [DATA_W-1:0]      gpr_wr_data_o,
    output logic                   done_o,
    output logic [31:0]            condition_register_o,
    // classic wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o
);

    logic [31:0]       cond_r;
    logic [31:0]       cond_nxt;
    logic              so_r;
    logic [31:0]       count_r;
    logic              ack_r;
    logic [31:0]       rdat_r;
    logic              gpr_en_r;
    logic [4:0]        gpr_idx_r;
    logic [DATA_W-1:0] gpr_data_r;
    logic              done_r;

    cflu_pkg::cflu_op_t op;
    logic [5:0]        opc;
    logic [9:0]        xo;
    logic [2:0]        dest_field_selector;
    logic [4:0]        dest_bit_selector;
    logic [4:0]        first_bit_selector;
    logic [4:0]        second_bit_selector;
    logic              record_bit;
    logic [DATA_W-1:0] cmp_rhs;
    logic [3:0]        cmp_field;
    logic [5:0]        clz_cnt;
    logic [3:0]        clz_field;
    logic              bit_a;
    logic              bit_b;
    logic              bit_res;
    logic              bus_wr;

    // field extraction; reserved bits are not examined at all
    assign opc                 = issue_instr_i[cflu_pkg::OPC_HI -: 6];
    assign xo                  = issue_instr_i[cflu_pkg::XO_HI -: 10];
    assign dest_field_selector = issue_instr_i[cflu_pkg::FLD_HI -: 3];
    assign dest_bit_selector   = issue_instr_i[cflu_pkg::DSTB_HI -: 5];
    assign first_bit_selector  = issue_instr_i[cflu_pkg::SRCA_HI -: 5];
    assign second_bit_selector = issue_instr_i[cflu_pkg::SRCB_HI -: 5];
    assign record_bit          = issue_instr_i[cflu_pkg::REC_POS];

    // decode; unknown encodings do nothing and signal no fault
    always_comb begin
        op = cflu_pkg::CFLU_OP_NONE;
        if (issue_valid_i) begin
            case (opc)
                cflu_pkg::OPC_X_FORM: begin
                    if (xo == cflu_pkg::XO_CMPL) begin
                        op = cflu_pkg::CFLU_OP_CMPL;
                    end else if (xo == cflu_pkg::XO_CLZ) begin
                        op = cflu_pkg::CFLU_OP_CLZ;
                    end
                end
                cflu_pkg::OPC_CMPLI: begin
                    op = cflu_pkg::CFLU_OP_CMPLI;
                end
                cflu_pkg::OPC_XL_FORM: begin
                    case (xo)
                        cflu_pkg::XO_CR_AND, cflu_pkg::XO_CR_ANDC, cflu_pkg::XO_CR_EQV,
                        cflu_pkg::XO_CR_NAND, cflu_pkg::XO_CR_NOR, cflu_pkg::XO_CR_OR,
                        cflu_pkg::XO_CR_ORC: begin
                            op = cflu_pkg::CFLU_OP_CRLOG;
                        end
                        default: begin
                            op = cflu_pkg::CFLU_OP_NONE;
                        end
                    endcase
                end
                default: begin
                    op = cflu_pkg::CFLU_OP_NONE;
                end
            endcase
        end
    end

    // unsigned compare, right operand register or zero-extended immediate
    always_comb begin
        if (op == cflu_pkg::CFLU_OP_CMPLI) begin
            cmp_rhs = {{(DATA_W-cflu_pkg::IMM_W){1'b0}}, issue_instr_i[cflu_pkg::IMM_W-1:0]};
        end else begin
            cmp_rhs = second_source_reg_i;
        end
        cmp_field = 4'h0;
        if (first_source_reg_i < cmp_rhs) begin
            cmp_field[3] = 1'b1;
        end else if (first_source_reg_i > cmp_rhs) begin
            cmp_field[2] = 1'b1;
        end else begin
            cmp_field[1] = 1'b1;
        end
        cmp_field[0] = so_r;
    end

    // leading zeros from the msb end
    always_comb begin
        clz_cnt = 6'(DATA_W);
        for (int i = 0; i < DATA_W; i++) begin
            if (count_source_reg_i[i]) begin
                clz_cnt = 6'(DATA_W - 1 - i);
            end
        end
        // signed view of the count against zero: never negative
        clz_field = {1'b0, clz_cnt != 6'h00, clz_cnt == 6'h00, so_r};
    end

    // bit k of the condition register is vector bit 31-k
    cflu_bit_pick #(
        .W (32)
    ) u_pick_a (
        .word_i (cond_r),
        .sel_i  (first_bit_selector),
        .bit_o  (bit_a)
    );

    cflu_bit_pick #(
        .W (32)
    ) u_pick_b (
        .word_i (cond_r),
        .sel_i  (second_bit_selector),
        .bit_o  (bit_b)
    );

    always_comb begin
        case (xo)
            cflu_pkg::XO_CR_AND:  bit_res = bit_a & bit_b;
            cflu_pkg::XO_CR_ANDC: bit_res = bit_a & ~bit_b;
            cflu_pkg::XO_CR_EQV:  bit_res = ~(bit_a ^ bit_b);
            cflu_pkg::XO_CR_NAND: bit_res = ~(bit_a & bit_b);
            cflu_pkg::XO_CR_NOR:  bit_res = ~(bit_a | bit_b);
            cflu_pkg::XO_CR_OR:   bit_res = bit_a | bit_b;
            cflu_pkg::XO_CR_ORC:  bit_res = bit_a | ~bit_b;
            default:              bit_res = bit_a;
        endcase
    end

    assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

    // bus write first, instruction update on top of it
    always_comb begin
        cond_nxt = cond_r;
        if (bus_wr && wb_adr_i == ADR_W'(cflu_pkg::OFS_COND)) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    cond_nxt[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
        end
        case (op)
            cflu_pkg::CFLU_OP_CMPL, cflu_pkg::CFLU_OP_CMPLI: begin
                cond_nxt[31 - 4*dest_field_selector -: 4] = cmp_field;
            end
            cflu_pkg::CFLU_OP_CLZ: begin
                if (record_bit) begin
                    cond_nxt[31 -: 4] = clz_field;
                end
            end
            cflu_pkg::CFLU_OP_CRLOG: begin
                cond_nxt[5'd31 - dest_bit_selector] = bit_res;
            end
            default: begin
                cond_nxt = cond_nxt;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cond_r <= cflu_pkg::COND_RST;
        end else begin
            cond_r <= cond_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            so_r <= cflu_pkg::SO_RST;
        end else if (bus_wr && wb_adr_i == ADR_W'(cflu_pkg::OFS_FXEXC) && wb_sel_i[3]) begin
            so_r <= wb_dat_i[cflu_pkg::SO_POS];
        end
    end

    // general register write-back, only the count writes one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gpr_en_r   <= 1'b0;
            gpr_idx_r  <= 5'h00;
            gpr_data_r <= '0;
            done_r     <= 1'b0;
        end else begin
            gpr_en_r <= (op == cflu_pkg::CFLU_OP_CLZ);
            done_r   <= (op != cflu_pkg::CFLU_OP_NONE);
            if (op == cflu_pkg::CFLU_OP_CLZ) begin
                gpr_idx_r  <= first_bit_selector;
                gpr_data_r <= DATA_W'(clz_cnt);
            end
        end
    end

    // executed-instruction counter, readable over the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= 32'h0000_0000;
        end else if (op != cflu_pkg::CFLU_OP_NONE) begin
            count_r <= count_r + 32'h0000_0001;
        end
    end

    // one wait state: ack the cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
            if (wb_adr_i == ADR_W'(cflu_pkg::OFS_COND)) begin
                rdat_r <= cond_r;
            end else if (wb_adr_i == ADR_W'(cflu_pkg::OFS_FXEXC)) begin
                rdat_r <= {so_r, 31'h0000_0000};
            end else if (wb_adr_i == ADR_W'(cflu_pkg::OFS_COUNT)) begin
                rdat_r <= count_r;
            end else begin
                rdat_r <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o             = ack_r;
    assign wb_dat_o             = rdat_r;
    assign gpr_wr_en_o          = gpr_en_r;
    assign gpr_wr_idx_o         = gpr_idx_r;
    assign gpr_wr_data_o        = gpr_data_r;
    assign done_o               = done_r;
    assign condition_register_o = cond_r;

endmodule

// single condition bit picked by its msb-first index
module cflu_bit_pick #(
    parameter int W = 32
) (
    input  wire logic [W-1:0]         word_i,
    input  wire logic [$clog2(W)-1:0] sel_i,
    output logic                      bit_o
);

    assign bit_o = word_i[W - 1 - int'(sel_i)];

endmodule

// ===== verif/cflu_gpr_model.sv
// decode-side register file model feeding operands
module cflu_gpr_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] ins_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  idx_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      a_o,
    output logic [31:0]      b_o,
    output logic [31:0]      s_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rf [32];
    always @(posedge clk_i) if (we_i) rf[idx_i] <= dat_i;
    assign a_o = rf[ins_i[20:16]];
    assign b_o = rf[ins_i[15:11]];
    assign s_o = rf[ins_i[25:21]];
endmodule

// ===== verif/cflu_unit_sva.sv
// port assertions of the condition-field logic unit
module cflu_unit_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        issue_valid_i,
    input wire logic [31:0] issue_instr_i,
    input wire logic [31:0] first_source_reg_i,
    input wire logic [31:0] second_source_reg_i,
    input wire logic [31:0] count_source_reg_i,
    input wire logic        gpr_wr_en_o,
    input wire logic [4:0]  gpr_wr_idx_o,
    input wire logic [31:0] gpr_wr_data_o,
    input wire logic        done_o,
    input wire logic [31:0] condition_register_o,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [31:0] iw  = issue_instr_i;
    wire [31:0] cr  = condition_register_o;
    wire        xf  = issue_valid_i && iw[31:26] == cflu_pkg::OPC_X_FORM;
    wire        cmp = xf && iw[10:1] == cflu_pkg::XO_CMPL;
    wire        clz = xf && iw[10:1] == cflu_pkg::XO_CLZ;
    wire        cnd = issue_valid_i && iw[31:26] == cflu_pkg::OPC_XL_FORM && iw[10:1] == cflu_pkg::XO_CR_AND;
    wire        bw  = wb_ack_o && wb_we_i;
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bad ack");
    property p_wb; gpr_wr_en_o |-> done_o; endproperty
    a_wb: assert property (p_wb) else $error("bad done");
    property p_cmp; cmp |=> cr[31 - 4 * $past(iw[25:23]) -: 3] == $past({first_source_reg_i < second_source_reg_i,
        first_source_reg_i > second_source_reg_i, first_source_reg_i == second_source_reg_i}); endproperty
    a_cmp: assert property (p_cmp) else $error("bad compare");
    property p_cnt; clz |=> gpr_wr_en_o && (gpr_wr_data_o == 32'h20 ? $past(count_source_reg_i) == 32'h0 :
        ($past(count_source_reg_i) >> (5'h1f - gpr_wr_data_o[4:0])) == 32'h1); endproperty
    a_cnt: assert property (p_cnt) else $error("bad count");
    property p_idx; clz |=> gpr_wr_idx_o == $past(iw[20:16]); endproperty
    a_idx: assert property (p_idx) else $error("bad index");
    property p_nrec; clz && !iw[0] && !bw |=> $stable(cr); endproperty
    a_nrec: assert property (p_nrec) else $error("cond changed");
    property p_rec; clz && iw[0] |=> cr[31:29] == {1'b0, gpr_wr_data_o != 32'h0, gpr_wr_data_o == 32'h0}; endproperty
    a_rec: assert property (p_rec) else $error("bad field zero");
    property p_and; cnd |=> cr[31 - $past(iw[25:21])] == $past(cr[31 - iw[20:16]] & cr[31 - iw[15:11]]); endproperty
    a_and: assert property (p_and) else $error("bad and");
    property p_one; cnd && !bw |=> ((cr ^ $past(cr)) & ~(32'h8000_0000 >> $past(iw[25:21]))) == 32'h0; endproperty
    a_one: assert property (p_one) else $error("other bits");
    c_cmp: cover property (cmp ##1 done_o);
    c_rec: cover property (clz && iw[0]);
    c_bw: cover property (bw);
endmodule
bind cflu_unit cflu_unit_sva u_sva (.*);

// ===== verif/tb_top.sv
// self-checking bench of the condition-field logic unit
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, iv = 1'b0, cyc = 1'b0, we = 1'b0, so_m = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] ins = 32'h0, wd = 32'h0, cr_m = 32'h0, st = 32'h26;
    logic [31:0] fa, fb, fs, rd, gd, cr, dq;
    logic [4:0]  gi;
    logic        ge, dn, ack;
    int          fail_count = 0, check_count = 0, n_ex = 0;
    logic [9:0]  xo_t [7] = '{cflu_pkg::XO_CR_AND, cflu_pkg::XO_CR_ANDC, cflu_pkg::XO_CR_EQV,
        cflu_pkg::XO_CR_NAND, cflu_pkg::XO_CR_NOR, cflu_pkg::XO_CR_OR, cflu_pkg::XO_CR_ORC};
    initial forever #10 clk_i = ~clk_i;
    cflu_unit u_dut (.clk_i, .rst_i, .issue_valid_i(iv), .issue_instr_i(ins), .first_source_reg_i(fa),
        .second_source_reg_i(fb), .count_source_reg_i(fs), .gpr_wr_en_o(ge), .gpr_wr_idx_o(gi), .gpr_wr_data_o(gd),
        .done_o(dn), .condition_register_o(cr), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dq), .wb_ack_o(ack));
    cflu_gpr_model u_gpr (.clk_i, .ins_i(ins), .we_i(ge), .idx_i(gi), .dat_i(gd), .a_o(fa), .b_o(fb), .s_o(fs));
    function automatic logic [31:0] xs();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction
    function automatic logic [5:0] clz(input logic [31:0] v);
        clz = 6'h20;
        for (int i = 0; i < 32; i++) if (v[i]) clz = 6'(31 - i);
    endfunction
    function automatic logic crl(input logic [3:0] k, input logic x, input logic y);
        case (k)
            4'h3: crl = x & y;
            4'h4: crl = x & ~y;
            4'h5: crl = ~(x ^ y);
            4'h6: crl = ~(x & y);
            4'h7: crl = ~(x | y);
            4'h8: crl = x | y;
            default: crl = x | ~y;
        endcase
    endfunction
    task automatic end_sim();
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        {cyc, we, adr, sel, wd} <= {1'b1, w, a, s, d};
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        rd = dq;
        cyc <= 1'b0;
        if (w && a == 4'h0) for (int j = 0; j < 4; j++) if (s[j]) cr_m[8*j +: 8] = d[8*j +: 8];
        if (w && a == 4'h4 && s[3]) so_m = d[31];
        if (n == 20) begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic op(input logic [3:0] k, input logic [4:0] m);
        logic [31:0] r, w, a, b;
        logic [5:0]  c;
        r = xs();
        r[14:5] = r[14:5] & {m, m};
        case (k)
            4'h0: w = {cflu_pkg::OPC_X_FORM, r[2:0], r[16:15], r[9:5], r[14:10], cflu_pkg::XO_CMPL, r[17]};
            4'h1: w = {cflu_pkg::OPC_CMPLI, r[2:0], 2'b00, r[9:5], m[4] ? r[31:16] : {15'h0000, r[16]}};
            4'h2: w = {cflu_pkg::OPC_X_FORM, r[9:5], r[14:10], r[20:16], cflu_pkg::XO_CLZ, r[15]};
            4'ha: w = {6'h00, r[25:0]};
            default: w = {cflu_pkg::OPC_XL_FORM, r[4:0], r[9:5], r[14:10], xo_t[k - 4'h3], 1'b0};
        endcase
        @(posedge clk_i);
        iv <= 1'b1;
        ins <= w;
        #1;
        a = fa;
        b = (k == 4'h1) ? {16'h0000, w[15:0]} : fb;
        c = clz(fs);
        if (k < 4'h2) cr_m[31 - 4 * w[25:23] -: 4] = {a < b, a > b, a == b, so_m};
        if (k == 4'h2 && w[0]) cr_m[31:28] = {1'b0, c != 6'h0, c == 6'h0, so_m};
        if (k > 4'h2 && k < 4'ha) cr_m[31 - w[25:21]] = crl(k, cr_m[31 - w[20:16]], cr_m[31 - w[15:11]]);
        n_ex += int'(k != 4'ha);
        @(posedge clk_i);
        iv <= 1'b0;
        #1;
        chk("done", {31'h0, k != 4'ha}, {31'h0, dn});
        chk("cond", cr_m, cr);
        chk("wr_en", {31'h0, k == 4'h2}, {31'h0, ge});
        if (k == 4'h2) chk("count", {26'h0, c}, gd);
        if (k == 4'h2) chk("idx", {27'h0, w[20:16]}, {27'h0, gi});
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("cond_rst", 32'h0, cr);
        wb(1'b0, 4'h4, 4'hf, 32'h0);
        chk("so_rst", 32'h0, rd);
        wb(1'b1, 4'h4, 4'hf, 32'hffff_ffff);
        wb(1'b0, 4'h4, 4'hf, 32'h0);
        chk("so", 32'h8000_0000, rd);
        wb(1'b0, 4'hc, 4'hf, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int i = 0; i < 32; i++) u_gpr.rf[i] <= (i < 4) ? {31'h0, i[0]} : xs();
        for (int k = 0; k < 11; k++) op(4'(k), 5'h1f);
        repeat (80) op(4'(xs() % 11), 5'h1f);
        wb(1'b1, 4'h4, 4'h8, 32'h0);
        repeat (80) op(4'(xs() % 11), 5'h03);
        wb(1'b1, 4'h0, 4'h5, 32'ha5c3_5a3c);
        wb(1'b0, 4'h0, 4'hf, 32'h0);
        chk("lanes", cr_m, rd);
        wb(1'b0, 4'h8, 4'hf, 32'h0);
        chk("exec", n_ex, rd);
        end_sim();
    end
endmodule
